// ### logic/rfid_consts.svh
// offsets, field positions, codes and timing of the anticollision responder
`ifndef RFID_CONSTS_SVH
`define RFID_CONSTS_SVH
// register byte offsets
`define OFF_CTRL      8'h00
`define OFF_ERRCODE   8'h04
`define OFF_UID_LO    8'h08
`define OFF_UID_HI    8'h0C
`define OFF_DSFID     8'h10
`define OFF_STATUS    8'h14
// ctrl bits and errcode enable bit
`define CTRL_GO       0
`define CTRL_DROP     1
`define CTRL_CLR_INIT 2
`define ERR_EN        8
// request flag positions
`define RQ_INVENTORY  2
`define RQ_AFI        4
`define RQ_ONE_SLOT   5
// command codes
`define CMD_INV       8'h01
`define CMD_FINV_I    8'hC1
`define CMD_FINIT     8'hC2
`define CMD_INV_I     8'hD1
`define CMD_INIT      8'hD2
// error codes
`define ERR_OPTION    8'h03
`define ERR_UNSPEC    8'h0F
`define ERR_BLK_LO    8'h10
`define ERR_BLK_HI    8'h15
// crc
`define CRC_INIT      16'hFFFF
`define CRC_POLY      16'h8408
// reset values
`define RST_DSFID     8'h00
`define RST_UID       64'h0000_0000_0000_0000
// timing
`define CLK_MHZ       250
`define T1_NOM_NS     320900
`define BIT_NS        37760
`define MASK_MAX_BITS 8'h40
`endif

// ### logic/rfid_pkg.sv
// types of the anticollision responder
`default_nettype none
package rfid_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_rx    = 3'b001,
    st_delay = 3'b011,
    st_tx    = 3'b010,
    st_wait  = 3'b110,
    st_hold  = 3'b111
  } rsp_state_t;
  typedef enum logic [1:0] {
    k_inv  = 2'b00,
    k_init = 2'b01,
    k_ext  = 2'b10
  } rsp_kind_t;
endpackage : rfid_pkg
`default_nettype wire

// ### logic/rfid_anticollision_responder.sv
// tag-side response framer and slotted anticollision responder
//
// Behaviour
// [R1] response goes out as SOF, flags, parameters and data, CRC, EOF
// [R2] flags byte: bit 1 error indicator, extension bit 0, others 0; the responder drives the error indicator in flags bit 0 (value 01h)
// [R3] error indicator set means a one-byte error code follows flags
// [R4] error codes 03h, 0Fh, 10h to 15h with fixed meanings
// [R5] never emit a code outside the defined set
// [R6] inventory: answer in the selected slot or stay silent
// [R7] reader sends mask length then mask, LSB first, zero padded
// [R8] field after the mask starts at next byte boundary; skip padding
// [R9] inventory request: flags, command, optional AFI, length, mask, CRC
// [R10] slot zero begins right after the request EOF
// [R11] reader advances slots with a lone EOF after any answer ends
// [R12] slot select flag: one slot width 0, or 16 slots width 4
// [R13] answer when low UID bits equal slot bits joined with mask
// [R14] SOF while waiting a slot marker aborts and takes a new request
// [R15] lone EOF steps slot number below total_slots-1, else ends
// [R16] every new inventory restarts slot numbering at 0
// [R17] initiated marker, set by Initiate, gates Inventory Initiated
// [R18] fast variants double the response data rate
// [R19] wait nominal response delay after EOF before answering or advancing
// [R20] reader waits its turnaround delay after a tag answer
// [R21] slot EOF of either modulation depth is recognised
// [R22] protocol timings carry plus or minus 32 carrier periods
// [R23] write-type requests are not held to the maximum response delay
// [R24] response delay counted by a counter loaded at the EOF edge
// [R25] CRC over flags and data, vicinity CRC-16, sent LSB first
`timescale 1ns/1ps
`default_nettype none
`include "rfid_consts.svh"

module rfid_anticollision_responder #(
  parameter int RESP_DELAY_CYC = `T1_NOM_NS * `CLK_MHZ / 1000,
  parameter int BYTE_CYC       = 8 * `BIT_NS * `CLK_MHZ / 1000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        link_clk,
  input  wire logic        link_sof,
  input  wire logic        link_eof,
  input  wire logic        link_valid,
  input  wire logic [7:0]  link_byte,
  output var  logic        tx_sof,
  output var  logic        tx_valid,
  output var  logic [7:0]  tx_byte,
  output var  logic        tx_eof,
  output var  logic        tx_fast,
  output var  logic        anticoll_active
);

  // ==========================================================
  // functions
  function automatic logic is_legal(input logic [7:0] c);
    return (c == `ERR_OPTION) || (c == `ERR_UNSPEC) ||
           ((c >= `ERR_BLK_LO) && (c <= `ERR_BLK_HI));
  endfunction : is_legal

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  function automatic logic slot_match(input logic [63:0] id, input logic [63:0] m,
                                      input logic [7:0] ml, input logic [3:0] sn,
                                      input logic one);
    logic [71:0] ref_v;
    logic [71:0] keep;
    logic [71:0] mlow;
    logic [7:0]  w;
    w     = one ? ml : ml + 8'h04;
    // slot bits sit just above the significant mask bits
    mlow  = {8'h00, m} & ~({72{1'b1}} << ml);
    ref_v = one ? mlow : (mlow | ({68'h0, sn} << ml));
    keep  = ~({72{1'b1}} << w);
    return ((({8'h00, id} ^ ref_v) & keep) == 72'h0);
  endfunction : slot_match

  // ==========================================================
  // link input synchroniser
  logic [11:0] sync1;
  logic [11:0] sync2;
  logic        lclk_d;
  logic        ev;
  logic        sof_ev;
  logic        eof_ev;
  logic        byte_ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1  <= 12'h000;
      sync2  <= 12'h000;
      lclk_d <= 1'b0;
    end else begin
      sync1  <= {link_clk, link_sof, link_eof, link_valid, link_byte};
      sync2  <= sync1;
      lclk_d <= sync2[11];
    end
  end

  // a lone EOF at either depth arrives as the same event
  assign ev      = sync2[11] & ~lclk_d;
  assign sof_ev  = ev & sync2[10];
  assign eof_ev  = ev & sync2[9]; // R21
  assign byte_ev = ev & sync2[8];

  // ==========================================================
  // registers and state
  rfid_pkg::rsp_state_t st;
  rfid_pkg::rsp_kind_t  kind;
  logic [7:0]  rx_buf [0:15];
  logic [3:0]  rx_cnt;
  logic [3:0]  sn;
  logic        one_slot;
  logic [7:0]  mlen;
  logic [63:0] mask;
  logic        initiated;
  logic [7:0]  last_cmd;
  logic [16:0] dly;
  logic [16:0] tcnt;
  logic [4:0]  tpos;
  logic [15:0] crc;
  logic [8:0]  errcode;
  logic [63:0] uid;
  logic [7:0]  dsfid;
  logic        sw_go;
  logic        sw_drop;
  logic        sw_clr;

  // ==========================================================
  // request parsing, mask placed after optional AFI
  logic [3:0]  lpos;
  logic [7:0]  rq_flags;
  logic [7:0]  rq_cmd;
  logic [7:0]  rq_mlen;
  logic [63:0] rq_mask;
  logic        rq_inv;
  logic        rq_gated;

  always_comb begin
    rq_flags = rx_buf[0];
    rq_cmd   = rx_buf[1];
    lpos     = rq_flags[`RQ_AFI] ? 4'd3 : 4'd2; // R9
    rq_mlen  = rx_buf[lpos];
    rq_mask  = 64'h0000_0000_0000_0000;
    // bytes past the mask sit at or above the mask length, where slot_match clears them, so padding is skipped
    for (int i = 0; i < 8; i++) begin
      rq_mask[i*8 +: 8] = rx_buf[4'(lpos + 4'd1 + 4'(i))]; // R8
    end
    rq_gated = (rq_cmd == `CMD_INV_I) || (rq_cmd == `CMD_FINV_I);
    rq_inv   = rq_flags[`RQ_INVENTORY] && ((rq_cmd == `CMD_INV) || rq_gated);
  end

  always_ff @(posedge pclk) begin
    if (st == rfid_pkg::st_rx && byte_ev) begin
      rx_buf[rx_cnt] <= sync2[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt <= 4'd0;
    end else if (sof_ev) begin
      rx_cnt <= 4'd0;
    end else if (st == rfid_pkg::st_rx && byte_ev && rx_cnt != 4'hF) begin
      rx_cnt <= rx_cnt + 4'd1;
    end
  end

  // ==========================================================
  // response byte selection
  logic [4:0] dlen;
  logic [7:0] dbyte;
  logic       tick;
  logic       hit;

  assign hit  = slot_match(uid, mask, mlen, sn, one_slot); // R13
  assign tick = (tcnt == 17'd0);

  always_comb begin
    dbyte = 8'h00;
    dlen  = 5'd10;
    if (kind == rfid_pkg::k_ext) begin
      dlen = errcode[`ERR_EN] ? 5'd2 : 5'd1; // R3
      if (tpos == 5'd1) begin
        dbyte = {7'h00, errcode[`ERR_EN]}; // R2
      end else begin
        dbyte = errcode[7:0];
      end
    end else if (tpos == 5'd2) begin
      dbyte = dsfid;
    end else if (tpos >= 5'd3 && tpos <= 5'd10) begin
      dbyte = uid[8*(int'(tpos)-3) +: 8];
    end
  end

  // ==========================================================
  // protocol state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= rfid_pkg::st_idle;
      kind     <= rfid_pkg::k_ext;
      sn       <= 4'd0;
      one_slot <= 1'b0;
      mlen     <= 8'h00;
      mask     <= 64'h0000_0000_0000_0000;
      last_cmd <= 8'h00;
      tx_fast  <= 1'b0;
      dly      <= 17'd0;
    end else begin
      case (st)
        rfid_pkg::st_idle: begin
          if (sof_ev) begin
            st <= rfid_pkg::st_rx;
          end
        end
        rfid_pkg::st_rx: begin
          if (eof_ev) begin
            last_cmd <= rq_cmd;
            dly      <= 17'(RESP_DELAY_CYC - 1); // R22 R24
            tx_fast  <= (rq_cmd == `CMD_FINV_I) || (rq_cmd == `CMD_FINIT); // R18
            if (rq_inv) begin
              // errored inventory, or gated one while not initiated, stays silent
              if (rq_mlen > `MASK_MAX_BITS || (rq_gated && !initiated)) begin // R17
                st <= rfid_pkg::st_idle;
              end else begin
                st       <= rfid_pkg::st_delay; // R10
                kind     <= rfid_pkg::k_inv;
                sn       <= 4'd0; // R16
                one_slot <= rq_flags[`RQ_ONE_SLOT]; // R12
                mlen     <= rq_mlen;
                mask     <= rq_mask;
              end
            end else if (rq_cmd == `CMD_INIT || rq_cmd == `CMD_FINIT) begin
              st   <= rfid_pkg::st_delay;
              kind <= rfid_pkg::k_init;
            end else begin
              st   <= rfid_pkg::st_delay;
              kind <= rfid_pkg::k_ext;
            end
          end
        end
        rfid_pkg::st_delay: begin
          if (dly != 17'd0) begin
            dly <= dly - 17'd1; // R19
          end else if (kind == rfid_pkg::k_inv) begin
            st <= hit ? rfid_pkg::st_tx : rfid_pkg::st_wait; // R6
          end else if (kind == rfid_pkg::k_init) begin
            st <= rfid_pkg::st_tx;
          end else begin
            // write-type requests finish on software's word, not a fixed bound
            st <= rfid_pkg::st_hold; // R23
          end
        end
        rfid_pkg::st_hold: begin
          if (sof_ev) begin
            st <= rfid_pkg::st_rx;
          end else if (sw_go) begin
            st <= rfid_pkg::st_tx;
          end else if (sw_drop) begin
            st <= rfid_pkg::st_idle;
          end
        end
        rfid_pkg::st_tx: begin
          if (tick && tpos == dlen + 5'd3) begin
            st <= (kind == rfid_pkg::k_inv) ? rfid_pkg::st_wait : rfid_pkg::st_idle;
          end
        end
        rfid_pkg::st_wait: begin
          if (sof_ev) begin
            st <= rfid_pkg::st_rx; // R14
          end else if (eof_ev) begin
            if (!one_slot && sn < 4'd15) begin
              sn  <= sn + 4'd1; // R15
              dly <= 17'(RESP_DELAY_CYC - 1);
              st  <= rfid_pkg::st_delay;
            end else begin
              st <= rfid_pkg::st_idle;
            end
          end
        end
        default: begin
          st <= rfid_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      initiated <= 1'b0;
    end else if (st == rfid_pkg::st_rx && eof_ev &&
                 (rq_cmd == `CMD_INIT || rq_cmd == `CMD_FINIT)) begin
      initiated <= 1'b1; // R17
    end else if (sw_clr) begin
      initiated <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      anticoll_active <= 1'b0;
    end else begin
      anticoll_active <= (kind == rfid_pkg::k_inv) && (st != rfid_pkg::st_idle) &&
                         (st != rfid_pkg::st_rx) && (st != rfid_pkg::st_hold);
    end
  end

  // ==========================================================
  // transmit sequencer: SOF, data, CRC low then high, EOF
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt <= 17'd0;
    end else if (st != rfid_pkg::st_tx) begin
      tcnt <= 17'd0;
    end else if (tick) begin
      tcnt <= tx_fast ? 17'(BYTE_CYC / 2 - 1) : 17'(BYTE_CYC - 1); // R18
    end else begin
      tcnt <= tcnt - 17'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tpos     <= 5'd0;
      crc      <= `CRC_INIT;
      tx_sof   <= 1'b0;
      tx_valid <= 1'b0;
      tx_eof   <= 1'b0;
      tx_byte  <= 8'h00;
    end else begin
      tx_sof   <= 1'b0;
      tx_valid <= 1'b0;
      tx_eof   <= 1'b0;
      if (st != rfid_pkg::st_tx) begin
        tpos <= 5'd0;
        crc  <= `CRC_INIT;
      end else if (tick) begin
        tpos <= tpos + 5'd1;
        if (tpos == 5'd0) begin
          tx_sof <= 1'b1; // R1
        end else if (tpos <= dlen) begin
          tx_valid <= 1'b1;
          tx_byte  <= dbyte;
          crc      <= crc_step(crc, dbyte); // R25
        end else if (tpos <= dlen + 5'd2) begin
          tx_valid <= 1'b1;
          tx_byte  <= (tpos == dlen + 5'd1) ? ~crc[7:0] : ~crc[15:8]; // R25
        end else begin
          tx_eof <= 1'b1; // R1
        end
      end
    end
  end

  // ==========================================================
  // apb slave, no wait states
  logic acc;
  logic mapped;

  assign acc    = psel & penable & pready;
  assign mapped = (paddr <= `OFF_STATUS) && (paddr[1:0] == 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      case (paddr)
        `OFF_ERRCODE: prdata <= {23'h00_0000, errcode};
        `OFF_UID_LO:  prdata <= uid[31:0];
        `OFF_UID_HI:  prdata <= uid[63:32];
        `OFF_DSFID:   prdata <= {24'h00_0000, dsfid};
        `OFF_STATUS:  prdata <= {12'h000, initiated, anticoll_active, one_slot,
                                 last_cmd, sn, st, kind};
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      errcode <= {1'b0, `ERR_UNSPEC};
      uid     <= `RST_UID;
      dsfid   <= `RST_DSFID;
      sw_go   <= 1'b0;
      sw_drop <= 1'b0;
      sw_clr  <= 1'b0;
    end else begin
      sw_go   <= acc & pwrite & (paddr == `OFF_CTRL) & pwdata[`CTRL_GO];
      sw_drop <= acc & pwrite & (paddr == `OFF_CTRL) & pwdata[`CTRL_DROP];
      sw_clr  <= acc & pwrite & (paddr == `OFF_CTRL) & pwdata[`CTRL_CLR_INIT];
      if (acc && pwrite) begin
        case (paddr)
          `OFF_ERRCODE: begin
            // reserved codes never reach the air
            errcode <= {pwdata[`ERR_EN],
                        is_legal(pwdata[7:0]) ? pwdata[7:0] : `ERR_UNSPEC}; // R4 R5
          end
          `OFF_UID_LO: uid[31:0]  <= pwdata;
          `OFF_UID_HI: uid[63:32] <= pwdata;
          `OFF_DSFID:  dsfid      <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic        in_frame;
  logic [31:0] dly_run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame <= 1'b0;
      dly_run  <= 32'd0;
    end else begin
      in_frame <= tx_sof ? 1'b1 : (tx_eof ? 1'b0 : in_frame);
      dly_run  <= (st == rfid_pkg::st_delay) ? dly_run + 32'd1 : 32'd0;
    end
  end

  sequence s_wait_eof;
    (st == rfid_pkg::st_wait) && eof_ev && !sof_ev;
  endsequence

  sequence s_enter_delay;
    (st == rfid_pkg::st_rx) && eof_ev ##1 (st == rfid_pkg::st_delay);
  endsequence

  AST_FRAME_ORDER: assert property (tx_eof |-> in_frame && !tx_valid) // R1
    else $error("end of frame without start");
  AST_DATA_IN_FRAME: assert property (tx_valid |-> in_frame) // R1
    else $error("byte outside frame");
  AST_FLAGS_RSV: assert property (tx_valid && $past(tpos) == 5'd1 |-> tx_byte[7:1] == 7'h00) // R2
    else $error("reserved flag bit set");
  AST_ERR_LEGAL: assert property (tx_valid && $past(tpos) == 5'd2 && // R5
                                  kind == rfid_pkg::k_ext && errcode[`ERR_EN]
                                  |-> is_legal(tx_byte))
    else $error("illegal error code sent");
  AST_SLOT_SILENT: assert property ($past(st) == rfid_pkg::st_delay && // R6
                                    st == rfid_pkg::st_tx && kind == rfid_pkg::k_inv |-> $past(hit))
    else $error("answer in foreign slot");
  AST_SN_RESTART: assert property (s_enter_delay |-> sn == 4'd0 || kind != rfid_pkg::k_inv) // R16
    else $error("slot not restarted");
  AST_SN_STEP: assert property (s_wait_eof ##1 (st == rfid_pkg::st_delay) // R15
                                |-> sn == $past(sn) + 4'd1)
    else $error("slot number not stepped");
  AST_ONE_SLOT_END: assert property (s_wait_eof ##0 one_slot |=> st == rfid_pkg::st_idle) // R12
    else $error("single slot did not end");
  AST_SOF_ABORT: assert property (st == rfid_pkg::st_wait && sof_ev |=> st == rfid_pkg::st_rx) // R14
    else $error("sof did not abort");
  AST_DELAY_LEN: assert property ($past(st) == rfid_pkg::st_delay && // R19
                                  st != rfid_pkg::st_delay |->
                                  $past(dly_run) == 32'(RESP_DELAY_CYC - 1))
    else $error("response delay wrong length");
  AST_INIT_GATE: assert property ((rq_gated && kind == rfid_pkg::k_inv) ##0 s_enter_delay // R17
                                  |-> initiated)
    else $error("initiated inventory without marker");

endmodule : rfid_anticollision_responder
`default_nettype wire

// ### testbench/reader_model.sv
// reader-side link model for the anticollision responder
`timescale 1ns/1ps
`default_nettype none
`include "rfid_consts.svh"
module reader_model (
  output var logic       link_clk,
  output var logic       link_sof,
  output var logic       link_eof,
  output var logic       link_valid,
  output var logic [7:0] link_byte
);
  initial begin
    link_clk   = 1'b0;
    link_sof   = 1'b0;
    link_eof   = 1'b0;
    link_valid = 1'b0;
    link_byte  = 8'h00;
  end
  // ==========
  // crc
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = `CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
      end
    end
    return ~c;
  endfunction : crc16
  // ==========
  // frames
  // data settles while the clock is low; clock stands still between frames
  task automatic tick(input logic s, input logic e, input logic v, input logic [7:0] b);
    link_sof   = s;
    link_eof   = e;
    link_valid = v;
    link_byte  = v ? b : ~link_byte;
    #16 link_clk = 1'b1;
    #16 link_clk = 1'b0;
    link_sof   = 1'b0;
    link_eof   = 1'b0;
    link_valid = 1'b0;
    link_byte  = ~link_byte;
  endtask : tick
  task automatic send_request(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    tick(1'b1, 1'b0, 1'b0, 8'h00);
    foreach (q[i]) tick(1'b0, 1'b0, 1'b1, q[i]);
    tick(1'b0, 1'b0, 1'b1, c[7:0]);
    tick(1'b0, 1'b0, 1'b1, c[15:8]);
    tick(1'b0, 1'b1, 1'b0, 8'h00);
  endtask : send_request
  // lone slot marker; depth is invisible here, both look the same
  task automatic send_eof();
    tick(1'b0, 1'b1, 1'b0, 8'h00);
  endtask : send_eof
endmodule : reader_model
`default_nettype wire

// ### testbench/rfid_anticollision_responder_tb_top.sv
// self-checking bench of the anticollision responder
`timescale 1ns/1ps
`default_nettype none
`include "rfid_consts.svh"
module rfid_anticollision_responder_tb_top;
  localparam int RD = 40;
  localparam int TURN = 24;
  localparam logic [7:0] MANY = 8'h01 << `RQ_INVENTORY;
  localparam logic [7:0] ONE = MANY | (8'h01 << `RQ_ONE_SLOT);
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, link_byte, tx_byte, dsfid;
  logic [31:0] pwdata, prdata, rd, lfsr_state;
  logic        link_clk, link_sof, link_eof, link_valid;
  logic        tx_sof, tx_valid, tx_eof, tx_fast, anticoll_active, fast_seen;
  logic [7:0]  got_q[$], exp_q[$], req[$];
  logic [63:0] uid;
  int          bad_count, checks_done, cycles, sofs, eofs, sof_at, t0;
  logic [7:0]  cmds[6] = '{`CMD_INV_I, `CMD_INIT, `CMD_INV_I, `CMD_FINV_I, `CMD_FINIT, `CMD_FINV_I};
  logic [7:0]  codes[8] = '{8'h03, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};

  rfid_anticollision_responder #(.RESP_DELAY_CYC(RD), .BYTE_CYC(16)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .link_sof(link_sof), .link_eof(link_eof),
    .link_valid(link_valid), .link_byte(link_byte), .tx_sof(tx_sof), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_eof(tx_eof), .tx_fast(tx_fast), .anticoll_active(anticoll_active));
  reader_model rdr (.link_clk(link_clk), .link_sof(link_sof), .link_eof(link_eof),
    .link_valid(link_valid), .link_byte(link_byte));

  always #2 pclk = ~pclk;
  // ==========
  // response capture and timeout
  always @(posedge pclk) begin
    cycles++;
    if (tx_sof === 1'b1) begin
      sofs++;
      sof_at = cycles;
      fast_seen = tx_fast;
    end
    if (tx_valid === 1'b1) got_q.push_back(tx_byte);
    if (tx_eof === 1'b1) eofs++;
    if (cycles == 40000) begin
      bad_count++;
      conclude();
    end
  end
  // ==========
  // helpers
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h8020_0003)};
    return lfsr_state;
  endfunction : rnd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic set_ids();
    apb(1'b1, `OFF_UID_LO, uid[31:0]);
    apb(1'b1, `OFF_UID_HI, uid[63:32]);
    apb(1'b1, `OFF_DSFID, {24'h0000_00, dsfid});
    exp_q = {8'h00, dsfid};
    for (int i = 0; i < 8; i++) exp_q.push_back(uid[8*i+:8]);
    add_crc();
  endtask : set_ids
  task automatic add_crc();
    logic [15:0] c;
    c = rdr.crc16(exp_q);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
  endtask : add_crc
  // mask goes LSB first, padded with zeros to whole bytes
  task automatic inv(input logic [7:0] fl, input logic [7:0] cmd, input int ml,
                     input logic [63:0] m);
    req = {fl, cmd, 8'(ml)};
    for (int i = 0; i < (ml + 7) / 8; i++) req.push_back(m[8*i+:8]);
    rdr.send_request(req);
    t0 = cycles;
  endtask : inv
  task automatic observe(input logic want, input logic fast);
    int n;
    got_q.delete();
    sofs = 0;
    eofs = 0;
    n = 0;
    while (eofs == 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    check("sof_count", sofs, want);
    check("eof_count", eofs, want);
    if (want) begin
      check("frame_len", got_q.size(), exp_q.size());
      foreach (exp_q[i]) check("frame_byte", got_q[i], exp_q[i]);
      check("fast_rate", fast_seen, fast);
    end
  endtask : observe
  // ==========
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {bad_count, checks_done, cycles, sofs, eofs} = '0;
    lfsr_state = 32'h5b03_49ae;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFF_ERRCODE, 32'h0);
    check("errcode_reset", rd, 32'h0000_000f);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    apb(1'b1, `OFF_ERRCODE, 32'h0000_0020);
    apb(1'b0, `OFF_ERRCODE, 32'h0);
    check("reserved_code", rd, 32'h0000_000f);
    foreach (codes[i]) begin
      apb(1'b1, `OFF_ERRCODE, {24'h0000_00, codes[i]});
      apb(1'b0, `OFF_ERRCODE, 32'h0);
      check("error_code", rd[7:0], codes[i]);
    end
    uid[31:0] = rnd();
    uid[63:32] = rnd();
    rd = rnd();
    dsfid = rd[7:0];
    set_ids();
    inv(ONE, `CMD_INV, 0, 64'h0);
    observe(1'b1, 1'b0);
    check("resp_delay", (sof_at - t0) inside {[RD:RD+4]}, 1'b1);
    for (int k = 0; k < 2; k++) begin
      inv(ONE, `CMD_INV, 11, {53'h0, uid[10:0] ^ (k ? 11'h008 : 11'h000)});
      observe(k == 0, 1'b0);
    end
    inv(MANY, `CMD_INV, 4, {60'h0, uid[3:0]});
    check("active", anticoll_active, 1'b1);
    for (int sn = 0; sn < 16; sn++) begin
      observe(sn == uid[7:4], 1'b0);
      repeat (TURN) @(posedge pclk);
      rdr.send_eof();
    end
    repeat (RD + 10) @(posedge pclk);
    check("seq_end", anticoll_active, 1'b0);
    uid[3:0] = 4'h0;
    set_ids();
    inv(MANY, `CMD_INV, 0, 64'h0);
    observe(1'b1, 1'b0);
    repeat (TURN) @(posedge pclk);
    rdr.send_eof();
    observe(1'b0, 1'b0);
    inv(MANY, `CMD_INV, 0, 64'h0);
    observe(1'b1, 1'b0);
    apb(1'b1, `OFF_CTRL, 32'h0000_0004);
    foreach (cmds[i]) begin
      if (i == 5) apb(1'b1, `OFF_CTRL, 32'h0000_0004);
      inv(ONE, cmds[i], 0, 64'h0);
      observe(i inside {[1:4]}, cmds[i][7:4] == 4'hc);
    end
    for (int e = 0; e < 3; e++) begin
      req = {8'h00, 8'h20};
      rdr.send_request(req);
      repeat (RD + 20) @(posedge pclk);
      apb(1'b1, `OFF_ERRCODE, {23'h0, e[0], 8'h13});
      apb(1'b1, `OFF_CTRL, (e == 2) ? 32'h0000_0002 : 32'h0000_0001);
      if (e == 1) exp_q = {8'h01, 8'h13};
      else exp_q = {8'h00};
      add_crc();
      observe(e < 2, 1'b0);
      if (e == 2) begin
        apb(1'b0, `OFF_STATUS, 32'h0);
        check("dropped_to_idle", rd[4:2], 3'b000);
      end
    end
    conclude();
  end
endmodule : rfid_anticollision_responder_tb_top
`default_nettype wire
